// ### src/psc_defines.vh
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
`define PSC_REG_CTRL 8'h00
`define PSC_REG_LIVE 8'h04
`define PSC_REG_STAT 8'h08
`define PSC_REG_MASK 8'h0C
`define PSC_CTRL_FW_OFF 0
`define PSC_EV_W 5
`define PSC_EV_OT_WARN 0
`define PSC_EV_OT_SHUT 1
`define PSC_EV_FAULT 2
`define PSC_EV_BUS_WR 3
`define PSC_EV_IN_LOST 4
`define PSC_CTL_ADDR_HI 4'hB
`define PSC_MEM_ADDR_HI 4'hA
`define PSC_NV_BYTES 96
`define PSC_ID_BYTES 128
`define PSC_PTR_LIVE 7'h60
`define PSC_PTR_CTRL 7'h61
`define PSC_CLK_HZ 28'h1312D00
`define PSC_OT_WARN_S 28'h000000A
`define PSC_OT_WARN_CYC (`PSC_OT_WARN_S * `PSC_CLK_HZ)
`define PSC_OT_CNT_W 28
`define PSC_SYNC_W 13
`endif

// ### src/psc_top.v
`timescale 1ns/1ns
`include "psc_defines.vh"
//Contract
//- Main output on while remote switch input high, off while low.
//- Remote off request or firmware off command alone turns output off.
//- Output stays off unless short enable pin is tied to return.
//- Memory writes blocked while guard high or open; allowed only when low. Code guards the 128-byte memory only.
//- Input-good line released high while input voltage is in range.
//- Output-good line released high while main output voltage present.
//- Over-temperature pulls warning low about ten seconds, then shuts down.
//- After thermal shutdown, restart when temperature normal; release warning.
//- Fault line low on thermal, overvoltage, overcurrent, input fault, no output.
//- Alert line released high unless an interrupt is pending.
//- Controller answers 1011+straps, memory answers 1010+straps on the bus.
//- Straps default high; host grounds them, up to eight modules share bus.
//- Host makes all bus clock pulses; device never drives clock.
//- Data line driven only for acknowledge or read data, else released.
//- Parameters reported only on host request; control accepted over bus.
//- Supply-present line permanently held at output return.
//- Controller offers 96 bytes of host-usable memory.
//- Separate 128-byte memory, guarded writes, holds identification.
module psc_top #(
	parameter [`PSC_OT_CNT_W-1:0] OT_WARN_CYC = `PSC_OT_WARN_CYC
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Register port
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// Control and sense pins
	input wire remote_on_i,
	input wire blade_enable_n_i,
	input wire write_guard_i,
	input wire strap_bit_two_i,
	input wire strap_bit_one_i,
	input wire strap_bit_zero_i,
	input wire input_in_range_i,
	input wire output_present_i,
	input wire overvoltage_protection_i,
	input wire overcurrent_protection_i,
	input wire over_temp_i,
	// Two-wire bus
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n_o,
	// Power and status lines
	output reg main_on_o,
	output reg input_good_flag_pd_n_o,
	output reg output_good_flag_pd_n_o,
	output reg temp_warn_pd_n_o,
	output reg fault_pd_n_o,
	output reg alert_pd_n_o,
	output reg supply_installed_flag_pd_n_o,
	output reg irq_o
);
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_ACK = 3'h2;
	localparam S_WR = 3'h3;
	localparam S_RD = 3'h4;
	localparam S_RACK = 3'h5;

	reg [`PSC_SYNC_W-1:0] sync1_reg;
	reg [`PSC_SYNC_W-1:0] sync2_reg;
	reg scl_prev_reg;
	reg sda_prev_reg;
	reg fw_off_reg;
	reg ot_shut_reg;
	reg [`PSC_OT_CNT_W-1:0] ot_cnt_reg;
	reg [`PSC_EV_W-1:0] stat_reg;
	reg [`PSC_EV_W-1:0] mask_reg;
	reg fault_prev_reg;
	reg in_prev_reg;
	reg [2:0] state_reg;
	reg [2:0] bitcnt_reg;
	reg [7:0] shreg_reg;
	reg [6:0] ptr_reg;
	reg sel_mem_reg;
	reg rw_reg;
	reg first_reg;
	reg got_reg;
	reg [7:0] nv_mem [0:`PSC_NV_BYTES-1];
	reg [7:0] id_mem [0:`PSC_ID_BYTES-1];

	wire remote_s = sync2_reg[12];
	wire blade_n_s = sync2_reg[11];
	wire guard_s = sync2_reg[10];
	wire [2:0] strap_s = sync2_reg[9:7];
	wire in_range_s = sync2_reg[6];
	wire out_pres_s = sync2_reg[5];
	wire ovp_s = sync2_reg[4];
	wire ocp_s = sync2_reg[3];
	wire hot_s = sync2_reg[2];
	wire scl_s = sync2_reg[1];
	wire sda_s = sync2_reg[0];

	wire scl_rise = scl_s & ~scl_prev_reg;
	wire scl_fall = ~scl_s & scl_prev_reg;
	wire bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	wire bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	wire fault_now = ot_shut_reg | ovp_s | ocp_s | ~in_range_s |
		~out_pres_s;
	wire on_next = remote_s & ~blade_n_s & ~fw_off_reg &
		~ot_shut_reg;
	// Live snapshot shared by the register port and the bus pointer
	wire [9:0] live = {strap_s, guard_s, ot_shut_reg, main_on_o, ~fault_now,
		~(hot_s | ot_shut_reg), out_pres_s, in_range_s};

	// Counter parks at its end value while shut; cooling clears it
	wire ot_end = hot_s & ~ot_shut_reg &
		(ot_cnt_reg == OT_WARN_CYC - 1'b1);
	// Seven-bit compare only; general call is not answered
	wire addr_ctl = shreg_reg[7:1] == {`PSC_CTL_ADDR_HI, strap_s};
	wire addr_mem = shreg_reg[7:1] == {`PSC_MEM_ADDR_HI, strap_s};
	wire wr_byte = (state_reg == S_WR) & got_reg & scl_fall & ~first_reg;
	wire wr_nv = wr_byte & ~sel_mem_reg & (ptr_reg < `PSC_NV_BYTES);
	// Guarded writes still get their ack; the store and its bus-write event are dropped
	wire wr_id = wr_byte & sel_mem_reg & ~guard_s;
	wire wr_ctl = wr_byte & ~sel_mem_reg & (ptr_reg == `PSC_PTR_CTRL);

	reg [7:0] rd_byte;
	always @* begin
		if (sel_mem_reg) begin
			rd_byte = id_mem[ptr_reg];
		end else if (ptr_reg < `PSC_NV_BYTES) begin
			rd_byte = nv_mem[ptr_reg];
		end else if (ptr_reg == `PSC_PTR_LIVE) begin
			rd_byte = live[7:0];
		end else if (ptr_reg == `PSC_PTR_CTRL) begin
			rd_byte = {7'h00, fw_off_reg};
		end else begin
			// Unused controller pointers read all ones
			rd_byte = 8'hFF;
		end
	end

	wire [`PSC_EV_W-1:0] ev;
	assign ev[`PSC_EV_OT_WARN] = hot_s & (ot_cnt_reg == {`PSC_OT_CNT_W{1'b0}})
		& ~ot_shut_reg;
	assign ev[`PSC_EV_OT_SHUT] = ot_end;
	assign ev[`PSC_EV_FAULT] = fault_now & ~fault_prev_reg;
	assign ev[`PSC_EV_BUS_WR] = wr_nv | wr_id | wr_ctl;
	assign ev[`PSC_EV_IN_LOST] = ~in_range_s & in_prev_reg;

	wire stat_clr = reg_wr_i & (reg_addr_i == `PSC_REG_STAT);
	// Set beats clear so an event in the clearing cycle survives
	wire [`PSC_EV_W-1:0] stat_next = ev |
		(stat_reg & ~(stat_clr ? reg_wdata_i[`PSC_EV_W-1:0] :
		{`PSC_EV_W{1'b0}}));
	// Interrupt uses this cycle's events, so alert is not a cycle late
	wire irq_next = |(stat_next & mask_reg);

	// Memories carry no reset; contents survive a logic reset
	always @(posedge clk_i) begin
		if (wr_nv) begin
			nv_mem[ptr_reg] <= shreg_reg;
		end
		if (wr_id) begin
			id_mem[ptr_reg] <= shreg_reg;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			// Bus lines reset to their idle high level: no false edge
			sync1_reg <= {{(`PSC_SYNC_W-2){1'b0}}, 2'h3};
			sync2_reg <= {{(`PSC_SYNC_W-2){1'b0}}, 2'h3};
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {remote_on_i, blade_enable_n_i, write_guard_i,
				strap_bit_two_i, strap_bit_one_i, strap_bit_zero_i,
				input_in_range_i, output_present_i,
				overvoltage_protection_i, overcurrent_protection_i,
				over_temp_i, scl_i, sda_i};
			sync2_reg <= sync1_reg;
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// Power control, thermal sequence, status lines
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ot_shut_reg <= 1'b0;
			ot_cnt_reg <= {`PSC_OT_CNT_W{1'b0}};
			main_on_o <= 1'b0;
			input_good_flag_pd_n_o <= 1'b1;
			output_good_flag_pd_n_o <= 1'b1;
			temp_warn_pd_n_o <= 1'b1;
			fault_pd_n_o <= 1'b1;
			alert_pd_n_o <= 1'b1;
			supply_installed_flag_pd_n_o <= 1'b0;
			// Fault taken as present in reset so release raises no event
			fault_prev_reg <= 1'b1;
			in_prev_reg <= 1'b0;
		end else begin
			if (!hot_s) begin
				ot_cnt_reg <= {`PSC_OT_CNT_W{1'b0}};
				ot_shut_reg <= 1'b0;
			end else if (ot_end) begin
				ot_shut_reg <= 1'b1;
			end else if (!ot_shut_reg) begin
				ot_cnt_reg <= ot_cnt_reg + 1'b1;
			end
			main_on_o <= on_next;
			input_good_flag_pd_n_o <= in_range_s;
			output_good_flag_pd_n_o <= out_pres_s;
			temp_warn_pd_n_o <= ~(hot_s | ot_shut_reg);
			fault_pd_n_o <= ~fault_now;
			alert_pd_n_o <= ~irq_next;
			supply_installed_flag_pd_n_o <= 1'b0;
			fault_prev_reg <= fault_now;
			in_prev_reg <= in_range_s;
		end
	end

	// Register port and interrupt logic
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			fw_off_reg <= 1'b0;
			stat_reg <= {`PSC_EV_W{1'b0}};
			mask_reg <= {`PSC_EV_W{1'b0}};
			irq_o <= 1'b0;
			reg_rdata_o <= 32'h00000000;
		end else begin
			stat_reg <= stat_next;
			irq_o <= irq_next;
			// Register port wins over a bus write in the same cycle
			if (reg_wr_i && reg_addr_i == `PSC_REG_CTRL) begin
				fw_off_reg <= reg_wdata_i[`PSC_CTRL_FW_OFF];
			end else if (wr_ctl) begin
				fw_off_reg <= shreg_reg[0];
			end
			if (reg_wr_i && reg_addr_i == `PSC_REG_MASK) begin
				mask_reg <= reg_wdata_i[`PSC_EV_W-1:0];
			end
			reg_rdata_o <= 32'h00000000;
			if (reg_rd_i) begin
				case (reg_addr_i)
				`PSC_REG_CTRL: begin
					reg_rdata_o <= {31'h00000000, fw_off_reg};
				end
				`PSC_REG_LIVE: begin
					reg_rdata_o <= {22'h000000, live};
				end
				`PSC_REG_STAT: begin
					reg_rdata_o <= {27'h0000000, stat_reg};
				end
				`PSC_REG_MASK: begin
					reg_rdata_o <= {27'h0000000, mask_reg};
				end
				default: begin
					reg_rdata_o <= 32'h00000000;
				end
				endcase
			end
		end
	end

	// Two-wire target; clock line is only ever sampled
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= S_IDLE;
			bitcnt_reg <= 3'h0;
			shreg_reg <= 8'h00;
			ptr_reg <= 7'h00;
			sel_mem_reg <= 1'b0;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			got_reg <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			// Open-drain: only the enable moves, the level is always low
			sda_o <= 1'b0;
			if (bus_start) begin
				state_reg <= S_ADDR;
				bitcnt_reg <= 3'h0;
				got_reg <= 1'b0;
				sda_oe_n_o <= 1'b1;
			end else if (bus_stop) begin
				state_reg <= S_IDLE;
				sda_oe_n_o <= 1'b1;
			end else if (scl_rise) begin
				case (state_reg)
				S_ADDR, S_WR: begin
					shreg_reg <= {shreg_reg[6:0], sda_s};
					bitcnt_reg <= bitcnt_reg + 1'b1;
					if (bitcnt_reg == 3'h7) begin
						got_reg <= 1'b1;
					end
				end
				S_RD: begin
					bitcnt_reg <= bitcnt_reg + 1'b1;
					if (bitcnt_reg == 3'h7) begin
						state_reg <= S_RACK;
					end
				end
				S_RACK: begin
					// Host ack asks for another byte; nack ends the read
					state_reg <= sda_s ? S_IDLE : S_ACK;
				end
				default: begin
					state_reg <= state_reg;
				end
				endcase
			end else if (scl_fall) begin
				case (state_reg)
				S_ADDR: begin
					if (got_reg) begin
						got_reg <= 1'b0;
						if (addr_ctl || addr_mem) begin
							sel_mem_reg <= addr_mem;
							rw_reg <= shreg_reg[0];
							first_reg <= ~shreg_reg[0];
							state_reg <= S_ACK;
							sda_oe_n_o <= 1'b0;
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				S_WR: begin
					if (got_reg) begin
						got_reg <= 1'b0;
						first_reg <= 1'b0;
						if (first_reg) begin
							ptr_reg <= shreg_reg[6:0];
						end else begin
							// Pointer wraps at the top of its seven bits
							ptr_reg <= ptr_reg + 1'b1;
						end
						state_reg <= S_ACK;
						sda_oe_n_o <= 1'b0;
					end
				end
				S_ACK: begin
					bitcnt_reg <= 3'h0;
					if (rw_reg) begin
						// Host asked, so the byte at the pointer goes out
						sda_oe_n_o <= rd_byte[7];
						shreg_reg <= {rd_byte[6:0], 1'b0};
						ptr_reg <= ptr_reg + 1'b1;
						state_reg <= S_RD;
					end else begin
						sda_oe_n_o <= 1'b1;
						state_reg <= S_WR;
					end
				end
				S_RD: begin
					sda_oe_n_o <= shreg_reg[7];
					shreg_reg <= {shreg_reg[6:0], 1'b0};
				end
				S_RACK: begin
					sda_oe_n_o <= 1'b1;
				end
				default: begin
					sda_oe_n_o <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule

// ### verif/psc_checker.sv
`timescale 1ns/1ns
`include "psc_defines.vh"
module psc_checker #(
	parameter [`PSC_OT_CNT_W-1:0] OT_WARN_CYC = `PSC_OT_WARN_CYC
) (
	// Clock and pins
	input wire clk_i,
	input wire rst_n_i,
	input wire remote_on_i,
	input wire blade_enable_n_i,
	input wire input_in_range_i,
	input wire output_present_i,
	input wire over_temp_i,
	input wire scl_i,
	// Design outputs
	input wire sda_oe_n_o,
	input wire main_on_o,
	input wire input_good_flag_pd_n_o,
	input wire temp_warn_pd_n_o,
	input wire fault_pd_n_o,
	input wire alert_pd_n_o,
	input wire irq_o,
	input wire supply_installed_flag_pd_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Counts raw hot cycles; sync lag is left as margin below
	logic [31:0] hot;
	always @(posedge clk_i) begin
		if (!rst_n_i || !over_temp_i)
			hot <= 32'h0;
		else
			hot <= hot + 32'h1;
	end
	sequence s_cool;
		!over_temp_i [*5];
	endsequence
	sequence s_off;
		(!remote_on_i || blade_enable_n_i) [*5];
	endsequence
	AST_PRESENT: assert property (!supply_installed_flag_pd_n_o)
		else $error("present line released");
	AST_ALERT: assert property (alert_pd_n_o == !irq_o)
		else $error("alert differs from irq");
	AST_OFF: assert property (s_off |-> !main_on_o)
		else $error("output on while not allowed");
	AST_IN: assert property (input_in_range_i [*5] |->
		input_good_flag_pd_n_o) else $error("input good held low");
	AST_IN_LOW: assert property (!input_in_range_i [*5] |->
		!input_good_flag_pd_n_o && !fault_pd_n_o)
		else $error("input loss not flagged");
	AST_NOOUT: assert property (!output_present_i [*5] |->
		!fault_pd_n_o) else $error("no output not flagged");
	AST_WARN: assert property (hot > 32'd5 |-> !temp_warn_pd_n_o)
		else $error("warning not pulled low");
	AST_SHUT: assert property (hot > OT_WARN_CYC + 8 |->
		!main_on_o && !fault_pd_n_o) else $error("no thermal shutdown");
	AST_COOL: assert property (s_cool |-> temp_warn_pd_n_o)
		else $error("warning not released");
	AST_SDA: assert property ($fell(sda_oe_n_o) |-> !scl_i)
		else $error("data pulled while clock high");
endmodule
bind psc_top psc_checker #(.OT_WARN_CYC(OT_WARN_CYC)) chk (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.remote_on_i(remote_on_i),
	.blade_enable_n_i(blade_enable_n_i),
	.input_in_range_i(input_in_range_i),
	.output_present_i(output_present_i),
	.over_temp_i(over_temp_i),
	.scl_i(scl_i),
	.sda_oe_n_o(sda_oe_n_o),
	.main_on_o(main_on_o),
	.input_good_flag_pd_n_o(input_good_flag_pd_n_o),
	.temp_warn_pd_n_o(temp_warn_pd_n_o),
	.fault_pd_n_o(fault_pd_n_o),
	.alert_pd_n_o(alert_pd_n_o),
	.irq_o(irq_o),
	.supply_installed_flag_pd_n_o(supply_installed_flag_pd_n_o)
);

// ### verif/psc_host_model.sv
`timescale 1ns/1ns
module psc_host_model (
	// Bus lines
	input wire sda_oe_n_i,
	output logic scl_o,
	output wire sda_o
);
	logic drv = 1'b1;
	// Open-drain with pull-up: any low party wins
	assign sda_o = drv & sda_oe_n_i;
	initial scl_o = 1'b1;
	task automatic bit_x(input logic b, output logic r);
		#100 drv = b;
		#100 scl_o = 1'b1;
		#100 r = sda_o;
		#100 scl_o = 1'b0;
	endtask
	// Odd offset keeps bus edges off the block's clock edges
	task automatic start();
		#113 drv = 1'b1;
		#100 scl_o = 1'b1;
		#100 drv = 1'b0;
		#100 scl_o = 1'b0;
	endtask
	task automatic stop();
		#100 drv = 1'b0;
		#100 scl_o = 1'b1;
		#100 drv = 1'b1;
		#100;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ha,
		output logic [7:0] q, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(ha, r);
		ak = !r;
	endtask
endmodule

// ### verif/psc_bench.sv
`timescale 1ns/1ns
module psc_bench;
	localparam OT = 20;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic remote_on_i = 1'b1;
	logic blade_enable_n_i = 1'b0;
	logic write_guard_i = 1'b1;
	logic strap_bit_two_i = 1'b1;
	logic strap_bit_one_i = 1'b0;
	logic strap_bit_zero_i = 1'b1;
	logic input_in_range_i = 1'b1;
	logic output_present_i = 1'b1;
	logic overvoltage_protection_i = 1'b0;
	logic overcurrent_protection_i = 1'b0;
	logic over_temp_i = 1'b0;
	wire [31:0] reg_rdata_o;
	wire scl, sda, sda_o, sda_oe_n_o, main_on_o, irq_o, fault_pd_n_o;
	wire input_good_flag_pd_n_o, output_good_flag_pd_n_o;
	wire temp_warn_pd_n_o, alert_pd_n_o, supply_installed_flag_pd_n_o;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int st = 0;
	int mk = 0;
	logic sh = 1'b0, fw = 1'b0, em, of, oi, ak;
	logic [31:0] seed = 32'h9C0F, r;
	logic [7:0] q;
	logic [7:0] bad [3] = '{8'h9A, 8'hB8, 8'hA2};
	psc_top #(.OT_WARN_CYC(OT)) uut (.scl_i(scl), .sda_i(sda), .*);
	psc_host_model host (.sda_oe_n_i(sda_oe_n_o), .scl_o(scl), .sda_o(sda));
	initial forever #25 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic flt();
		return sh | !input_in_range_i | !output_present_i |
			overvoltage_protection_i | overcurrent_protection_i;
	endfunction
	function automatic logic [31:0] live();
		return {22'h0, 3'h5, write_guard_i, sh, em, !flt(),
			!over_temp_i, output_present_i, input_in_range_i};
	endfunction
	task automatic cmp(input string n, input logic [31:0] e, s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic pin(input string n, input logic e, s);
		cmp(n, {31'h0, e}, {31'h0, s});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		cmp("rdata", e, reg_rdata_o);
		@(negedge clk_i);
		cmp("rdata_idle", 32'h0, reg_rdata_o);
	endtask
	task automatic pins();
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		em = remote_on_i & !blade_enable_n_i & !fw & !sh;
		pin("main", em, main_on_o);
		pin("ingood", input_in_range_i, input_good_flag_pd_n_o);
		pin("outgood", output_present_i, output_good_flag_pd_n_o);
		pin("warn", !over_temp_i, temp_warn_pd_n_o);
		pin("fault", !flt(), fault_pd_n_o);
		pin("irq", |(st & mk), irq_o);
		pin("sda_o", 1'b0, sda_o);
		pin("alert", !(|(st & mk)), alert_pd_n_o);
		pin("present", 1'b0, supply_installed_flag_pd_n_o);
		rd(8'h04, live());
	endtask
	task automatic iw(input logic [7:0] a, p, d);
		host.start();
		host.xfer(a, 1'b1, q, ak);
		pin("ack", 1'b1, ak);
		host.xfer(p, 1'b1, q, ak);
		host.xfer(d, 1'b1, q, ak);
		pin("ack", 1'b1, ak);
		host.stop();
	endtask
	task automatic ir(input logic [7:0] a, p, e);
		host.start();
		host.xfer(a, 1'b1, q, ak);
		host.xfer(p, 1'b1, q, ak);
		host.start();
		host.xfer(a | 8'h01, 1'b1, q, ak);
		host.xfer(8'hFF, 1'b1, q, ak);
		cmp("byte", {24'h0, e}, {24'h0, q});
		host.stop();
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			of = flt();
			oi = input_in_range_i;
			@(posedge clk_i);
			remote_on_i <= r[0] | r[1];
			blade_enable_n_i <= r[2] & r[3];
			{input_in_range_i, output_present_i} <= r[5:4];
			{overvoltage_protection_i, overcurrent_protection_i} <= r[7:6];
			write_guard_i <= r[8];
			fw = r[9] & r[10];
			mk = r[15:11];
			wr(8'h00, {31'h0, fw});
			wr(8'h0C, mk);
			if (flt() && !of)
				st |= 4;
			if (oi && !input_in_range_i)
				st |= 16;
			pins();
			rd(8'h0C, mk);
			rd(8'h08, st);
			wr(8'h08, 32'h1F);
			st = 0;
		end
		@(posedge clk_i);
		{remote_on_i, input_in_range_i, output_present_i} <= 3'h7;
		{overvoltage_protection_i, overcurrent_protection_i} <= 2'h0;
		blade_enable_n_i <= 1'b0;
		write_guard_i <= 1'b1;
		fw = 1'b0;
		wr(8'h00, 32'h0);
		mk = 31;
		wr(8'h0C, 32'h1F);
		pins();
		@(posedge clk_i);
		over_temp_i <= 1'b1;
		st = 1;
		pins();
		repeat (OT) @(posedge clk_i);
		sh = 1'b1;
		st = 7;
		pins();
		rd(8'h08, st);
		wr(8'h08, 32'h7);
		st = 0;
		pins();
		@(posedge clk_i);
		over_temp_i <= 1'b0;
		sh = 1'b0;
		pins();
		iw(8'hBA, 8'h5F, 8'hC3);
		st = 8;
		ir(8'hBA, 8'h5F, 8'hC3);
		@(posedge clk_i);
		write_guard_i <= 1'b0;
		iw(8'hAA, 8'h7F, 8'h3C);
		@(posedge clk_i);
		write_guard_i <= 1'b1;
		iw(8'hAA, 8'h7F, 8'h96);
		ir(8'hAA, 8'h7F, 8'h3C);
		iw(8'hBA, 8'h61, 8'h01);
		fw = 1'b1;
		pins();
		r = live();
		ir(8'hBA, 8'h60, r[7:0]);
		host.start();
		host.xfer(8'hBA, 1'b1, q, ak);
		host.xfer(8'h5F, 1'b1, q, ak);
		host.start();
		host.xfer(8'hBB, 1'b1, q, ak);
		host.xfer(8'hFF, 1'b0, q, ak);
		cmp("burst0", 32'hC3, {24'h0, q});
		host.xfer(8'hFF, 1'b1, q, ak);
		cmp("burst1", {24'h0, r[7:0]}, {24'h0, q});
		host.stop();
		foreach (bad[i]) begin
			host.start();
			host.xfer(bad[i], 1'b1, q, ak);
			pin("ack", 1'b0, ak);
			host.stop();
		end
		rd(8'h08, st);
		test_done();
	end
endmodule
